// ==== rtl/pfd_consts.svh ====
// constants for the parcel format decoder: widths, field positions, opcodes, register map
`ifndef PFD_CONSTS_SVH
`define PFD_CONSTS_SVH

`define PFD_WORD_W        60
`define PFD_PARCEL_W      15
`define PFD_NPARCEL       4
`define PFD_ADDR_W        18
`define PFD_RSEL_W        3
`define PFD_NREG          8
`define PFD_PTR_LAST      2'h3
`define PFD_PTR_FIRST     2'h0

// fields of a two-parcel (30-bit) instruction image
`define PFD_OPC_HI        29
`define PFD_OPC_LO        24
`define PFD_SI_HI         23
`define PFD_SI_LO         21
`define PFD_SJ_HI         20
`define PFD_SJ_LO         18
`define PFD_SK_HI         17
`define PFD_SK_LO         15
`define PFD_KOP_HI        17
`define PFD_KOP_LO        0

// fields of the full-word compare/move format
`define PFD_CM_OPC_HI     59
`define PFD_CM_OPC_LO     51
`define PFD_CM_HI9_HI     50
`define PFD_CM_HI9_LO     42
`define PFD_CM_HI3_HI     50
`define PFD_CM_HI3_LO     48
`define PFD_CM_LOW_HI     47
`define PFD_CM_LOW_LO     44
`define PFD_CM_ILOW_HI    41
`define PFD_CM_ILOW_LO    38
`define PFD_CM_SOFF_HI    43
`define PFD_CM_SOFF_LO    40
`define PFD_CM_ROFF_HI    39
`define PFD_CM_ROFF_LO    36
`define PFD_CM_SADR_HI    35
`define PFD_CM_SADR_LO    18
`define PFD_CM_RADR_HI    17
`define PFD_CM_RADR_LO    0

// opcodes
`define PFD_OPC_GRP46     6'h26
`define PFD_OPC_IND_MOVE  9'h134
`define PFD_OPC_PASS2_LO  6'h30
`define PFD_OPC_PASS2_HI  6'h32
`define PFD_LONG_OPC_MASK 64'h0707_0700_0000_00FE

// wishbone register map
`define PFD_REG_CTRL      8'h00
`define PFD_REG_STATUS    8'h04
`define PFD_REG_ISSUED    8'h08
`define PFD_CTRL_RESET    2'h0
`define PFD_CTRL_REDUCED  0
`define PFD_CTRL_HALT     1

`endif

// ==== rtl/pfd_pkg.sv ====
// types shared by the parcel format decoder and its bench
package pfd_pkg;

	typedef enum logic [2:0] {
		PFD_LEN_ONE  = 3'b001,
		PFD_LEN_TWO  = 3'b010,
		PFD_LEN_FULL = 3'b100
	} pfd_len_e;

	typedef enum logic [2:0] {
		PFD_RF_A = 3'b001,
		PFD_RF_B = 3'b010,
		PFD_RF_X = 3'b100
	} pfd_rf_e;

	typedef enum logic [1:0] {
		PFD_ST_EMPTY = 2'b01,
		PFD_ST_WORD  = 2'b10
	} pfd_state_e;

	typedef struct packed {
		logic        indirect;
		logic [8:0]  char_count_high;
		logic [3:0]  char_count_low;
		logic [12:0] char_count;
		logic [3:0]  source_char_offset;
		logic [3:0]  result_char_offset;
		logic [17:0] source_field_addr;
		logic [17:0] result_field_addr;
	} pfd_cm_s;

	typedef struct packed {
		pfd_len_e    len;
		logic [1:0]  parcel_idx;
		logic [5:0]  primary_opcode;
		logic [8:0]  primary_opcode_alt;
		logic [2:0]  sel_i;
		logic [2:0]  sel_j;
		logic [2:0]  sel_k;
		logic [5:0]  shift_mask_count;
		logic [17:0] k_operand;
		logic        is_pass;
		logic        reg_write_en;
		logic        illegal;
		pfd_cm_s     cm;
	} pfd_dec_s;

	typedef struct packed {
		logic        en;
		pfd_rf_e     file;
		logic [2:0]  sel;
		logic [59:0] data;
	} pfd_wr_s;

	typedef struct packed {
		logic [59:0] x_j;
		logic [59:0] x_k;
		logic [17:0] a_j;
		logic [17:0] b_j;
		logic [17:0] b_k;
	} pfd_opnd_s;

endpackage : pfd_pkg

// ==== rtl/pfd_decoder.sv ====
// parcel splitter, format decoder and operand register files of the central processor
// Contract
// - every program word is four 15-bit parcels, decoded parcel by parcel
// - parcel zero is the top 15 bits, later parcels toward the low end
// - full variant accepts one-, two- and four-parcel instructions by format
// - reduced variant has only one- and two-parcel forms, no full-word form
// - reduced variant: two-parcel start in parcel 3 gets an all-zero second parcel
// - branch targets start a fresh word; rest of the word after a branch is dropped
// - 460xx-463xx are one-parcel passes; in the reduced variant all 46xxx are
// - 60xxx-62xxx with first selector zero act as two-parcel passes, no write
// - three 3-bit selectors each pick one of eight registers
// - second and third selectors together read as a 6-bit shift or mask count
// - two-parcel forms deliver an 18-bit constant or address operand
// - eight 18-bit address registers, chosen by the selectors
// - eight 18-bit index registers; index zero reads zero, ignores writes
// - eight 60-bit operand registers, chosen by the selectors
// - compare/move carries source and result character offsets in first word
// - compare/move carries two 18-bit addresses of the leftmost characters
// - character count joins 4 low bits with 9 (indirect) or 3 (direct) high bits
// - unused instruction bits are ignored and never change behaviour
`timescale 1ns/1ps

`include "pfd_consts.svh"

module pfd_decoder #(
	parameter logic [63:0] LONG_OPC_MASK = `PFD_LONG_OPC_MASK,
	parameter int          PARCEL_W      = `PFD_PARCEL_W,
	parameter int          NREG          = `PFD_NREG
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  word_valid,
	input  wire logic [59:0]           word_data,
	output logic                       word_ready,
	input  wire logic                  branch_taken,
	output logic                       dec_valid,
	input  wire logic                  dec_ready,
	output pfd_pkg::pfd_dec_s          dec,
	output pfd_pkg::pfd_opnd_s         opnd,
	input  wire pfd_pkg::pfd_wr_s      rf_wr
);
	import pfd_pkg::*;

	if (PARCEL_W != `PFD_PARCEL_W || NREG != `PFD_NREG) begin : g_chk
		$error("pfd_decoder: parcel width must be 15 and register count 8");
	end

	// group 46 carries the pass and full-word forms and may never be two-parcel
	if (LONG_OPC_MASK[`PFD_OPC_GRP46]) begin : g_chk_mask
		$error("pfd_decoder: opcode group 46 cannot be a two-parcel format");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	pfd_state_e             state_r;
	pfd_state_e             state_nxt;
	logic [59:0]            word_r;
	logic [1:0]             ptr_r;
	logic [1:0]             ptr_nxt;
	logic [1:0]             ctrl_r;
	logic [31:0]            issued_r;
	logic                   ack_r;
	logic [31:0]            rdata_r;
	logic                   dec_valid_r;
	pfd_dec_s               dec_r;
	pfd_opnd_s              opnd_r;

	logic [17:0]            a_rf [`PFD_NREG];
	logic [17:0]            b_rf [`PFD_NREG];
	logic [59:0]            x_rf [`PFD_NREG];

	////////////////////////////////////////////////////////////////////////////
	// parcel split

	logic [14:0]            parcel [`PFD_NPARCEL];

	for (genvar p = 0; p < `PFD_NPARCEL; p++) begin : g_parcel
		assign parcel[p] = word_r[`PFD_WORD_W-1-p*`PFD_PARCEL_W -: `PFD_PARCEL_W];
	end

	wire         reduced    = ctrl_r[`PFD_CTRL_REDUCED];
	wire         halt       = ctrl_r[`PFD_CTRL_HALT];
	wire         at_last    = (ptr_r == `PFD_PTR_LAST);
	wire [1:0]   ptr_inc    = ptr_r + 2'h1;
	wire [14:0]  p_first    = parcel[ptr_r];
	// a second parcel never comes from the next word
	wire [14:0]  p_second   = at_last ? 15'h0000 : parcel[ptr_inc];
	wire [29:0]  ins        = {p_first, p_second};

	////////////////////////////////////////////////////////////////////////////
	// format decode

	wire [5:0]   opc6       = ins[`PFD_OPC_HI:`PFD_OPC_LO];
	wire [2:0]   s_i        = ins[`PFD_SI_HI:`PFD_SI_LO];
	wire [2:0]   s_j        = ins[`PFD_SJ_HI:`PFD_SJ_LO];
	wire [2:0]   s_k        = ins[`PFD_SK_HI:`PFD_SK_LO];
	wire [8:0]   opc9       = {opc6, s_i};
	wire         grp46      = (opc6 == `PFD_OPC_GRP46);
	wire         fullword   = !reduced && grp46 && s_i[2];
	wire         pass1      = grp46 && (reduced || !s_i[2]);
	wire         long_fmt   = LONG_OPC_MASK[opc6] && !grp46;
	wire         pass2_opc  = (opc6 >= `PFD_OPC_PASS2_LO) && (opc6 <= `PFD_OPC_PASS2_HI);
	wire         pass2      = long_fmt && pass2_opc && (s_i == 3'h0);
	// an illegal form ends the word so the fetch side can move on
	wire         bad_full   = fullword && (ptr_r != `PFD_PTR_FIRST);
	wire         bad_span   = long_fmt && at_last && !reduced;
	wire         illegal    = bad_full || bad_span;
	wire [2:0]   ptr_sum    = {1'b0, ptr_r} + (long_fmt ? 3'h2 : 3'h1);
	wire         ends_word  = fullword || illegal || ptr_sum[2];
	wire [17:0]  k_operand  = long_fmt ? ins[`PFD_KOP_HI:`PFD_KOP_LO] : 18'h00000;

	pfd_len_e    len;
	assign len = fullword ? PFD_LEN_FULL : (long_fmt ? PFD_LEN_TWO : PFD_LEN_ONE);

	// compare/move descriptors; fields that a form leaves unused read as zero
	wire         cm_ind     = (word_r[`PFD_CM_OPC_HI:`PFD_CM_OPC_LO] == `PFD_OPC_IND_MOVE);
	wire [8:0]   cm_hi9     = word_r[`PFD_CM_HI9_HI:`PFD_CM_HI9_LO];
	wire [2:0]   cm_hi3     = word_r[`PFD_CM_HI3_HI:`PFD_CM_HI3_LO];
	wire [3:0]   cm_low     = word_r[`PFD_CM_LOW_HI:`PFD_CM_LOW_LO];
	wire [8:0]   cm_high    = cm_ind ? cm_hi9 : {6'h00, cm_hi3};
	wire [3:0]   cm_lowf    = cm_ind ? word_r[`PFD_CM_ILOW_HI:`PFD_CM_ILOW_LO] : cm_low;

	pfd_cm_s     cm;
	assign cm.indirect           = cm_ind;
	assign cm.char_count_high    = cm_high;
	assign cm.char_count_low     = cm_lowf;
	assign cm.char_count         = {cm_high, cm_lowf};
	assign cm.source_char_offset = cm_ind ? 4'h0 : word_r[`PFD_CM_SOFF_HI:`PFD_CM_SOFF_LO];
	assign cm.result_char_offset = cm_ind ? 4'h0 : word_r[`PFD_CM_ROFF_HI:`PFD_CM_ROFF_LO];
	assign cm.source_field_addr  = word_r[`PFD_CM_SADR_HI:`PFD_CM_SADR_LO];
	assign cm.result_field_addr  = word_r[`PFD_CM_RADR_HI:`PFD_CM_RADR_LO];

	pfd_dec_s    dec_nxt;
	assign dec_nxt.len                = len;
	assign dec_nxt.parcel_idx         = ptr_r;
	assign dec_nxt.primary_opcode     = opc6;
	assign dec_nxt.primary_opcode_alt = opc9;
	// selector fields are passed only by formats that use them
	assign dec_nxt.sel_i              = fullword ? 3'h0 : s_i;
	assign dec_nxt.sel_j              = fullword ? 3'h0 : s_j;
	assign dec_nxt.sel_k              = (fullword || long_fmt) ? 3'h0 : s_k;
	assign dec_nxt.shift_mask_count   = (fullword || long_fmt) ? 6'h00 : {s_j, s_k};
	assign dec_nxt.k_operand          = k_operand;
	assign dec_nxt.is_pass            = pass1 || pass2;
	assign dec_nxt.reg_write_en       = !(pass1 || pass2 || illegal || fullword);
	assign dec_nxt.illegal            = illegal;
	assign dec_nxt.cm                 = fullword ? cm : '0;

	////////////////////////////////////////////////////////////////////////////
	// issue control

	wire         have_word  = (state_r == PFD_ST_WORD);
	wire         out_free   = !dec_valid_r || dec_ready;
	wire         issue      = have_word && out_free && !halt && !branch_taken;
	wire         load_word  = word_valid && word_ready;

	assign word_ready = (state_r == PFD_ST_EMPTY) && !branch_taken;

	always_comb begin
		state_nxt = state_r;
		ptr_nxt   = ptr_r;
		case (state_r)
			PFD_ST_EMPTY: begin
				if (load_word) begin
					state_nxt = PFD_ST_WORD;
					ptr_nxt   = `PFD_PTR_FIRST;
				end
			end
			PFD_ST_WORD: begin
				if (branch_taken) begin
					state_nxt = PFD_ST_EMPTY;
					ptr_nxt   = `PFD_PTR_FIRST;
				end else if (issue && ends_word) begin
					state_nxt = PFD_ST_EMPTY;
					ptr_nxt   = `PFD_PTR_FIRST;
				end else if (issue) begin
					ptr_nxt   = ptr_sum[1:0];
				end
			end
			default: begin
				state_nxt = PFD_ST_EMPTY;
				ptr_nxt   = `PFD_PTR_FIRST;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= PFD_ST_EMPTY;
			ptr_r   <= `PFD_PTR_FIRST;
		end else begin
			state_r <= state_nxt;
			ptr_r   <= ptr_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_r <= '0;
		end else if (load_word) begin
			word_r <= word_data;
		end
	end

	// a taken branch also voids the decoded instruction still waiting
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dec_valid_r <= 1'b0;
		end else if (branch_taken) begin
			dec_valid_r <= 1'b0;
		end else if (issue) begin
			dec_valid_r <= 1'b1;
		end else if (dec_ready) begin
			dec_valid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dec_r <= '0;
		end else if (issue) begin
			dec_r <= dec_nxt;
		end
	end

	// operands are read as the files stand before a write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opnd_r <= '0;
		end else if (issue) begin
			opnd_r.x_j <= x_rf[dec_nxt.sel_j];
			opnd_r.x_k <= x_rf[dec_nxt.sel_k];
			opnd_r.a_j <= a_rf[dec_nxt.sel_j];
			opnd_r.b_j <= b_rf[dec_nxt.sel_j];
			opnd_r.b_k <= b_rf[dec_nxt.sel_k];
		end
	end

	assign dec_valid = dec_valid_r;
	assign dec       = dec_r;
	assign opnd      = opnd_r;

	////////////////////////////////////////////////////////////////////////////
	// operand register files

	for (genvar r = 0; r < `PFD_NREG; r++) begin : g_rf
		wire hit  = rf_wr.en && (rf_wr.sel == 3'(r));
		wire wr_a = hit && (rf_wr.file == PFD_RF_A);
		wire wr_x = hit && (rf_wr.file == PFD_RF_X);
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				a_rf[r] <= '0;
			end else if (wr_a) begin
				a_rf[r] <= rf_wr.data[`PFD_ADDR_W-1:0];
			end
		end
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				x_rf[r] <= '0;
			end else if (wr_x) begin
				x_rf[r] <= rf_wr.data;
			end
		end
		if (r == 0) begin : g_zero
			assign b_rf[r] = 18'h00000;
		end else begin : g_breg
			wire wr_b = hit && (rf_wr.file == PFD_RF_B);
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					b_rf[r] <= '0;
				end else if (wr_b) begin
					b_rf[r] <= rf_wr.data[`PFD_ADDR_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wishbone slave

	// a strobe still held after ack starts a new transfer one cycle later
	wire         wb_req     = wb_cyc_i && wb_stb_i && !ack_r;
	wire         wb_wr      = wb_req && wb_we_i;
	wire         hit_ctrl   = (wb_adr_i == `PFD_REG_CTRL);
	wire         hit_status = (wb_adr_i == `PFD_REG_STATUS);
	wire         hit_issued = (wb_adr_i == `PFD_REG_ISSUED);
	wire         wr_ctrl    = wb_wr && hit_ctrl && wb_sel_i[0];
	wire         wr_issued  = wb_wr && hit_issued && wb_sel_i[0];
	wire [31:0]  status_val = {27'h0000000, dec_valid_r, have_word, halt, ptr_r};
	wire [31:0]  rd_mux     = hit_ctrl   ? {30'h00000000, ctrl_r} :
	                          hit_status ? status_val :
	                          hit_issued ? issued_r : 32'h00000000;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_req;
		end
	end

	// read data stands only while ack is high
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= wb_req ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `PFD_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_r <= wb_dat_i[1:0];
		end
	end

	// a clear that meets an issue keeps that issue in the count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			issued_r <= '0;
		end else if (wr_issued) begin
			issued_r <= issue ? 32'h00000001 : 32'h00000000;
		end else if (issue) begin
			issued_r <= issued_r + 32'h00000001;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

endmodule : pfd_decoder

// ==== tb/pfd_decoder_sva.sv ====
// concurrent checks on the parcel format decoder ports
`timescale 1ns/1ps

module pfd_decoder_sva
	import pfd_pkg::*;
(
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_ack_o,
	input wire logic              branch_taken,
	input wire logic              dec_valid,
	input wire logic              dec_ready,
	input wire pfd_pkg::pfd_dec_s dec
);
	import pfd_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////////
	chk_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack missing one cycle after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	chk_two_no_wrap: assert property (
		dec_valid && dec.len == PFD_LEN_TWO && dec.parcel_idx == 2'h3
		|-> dec.illegal || dec.k_operand[14:0] == 15'h0)
		else $error("two-parcel form in last parcel took a nonzero second parcel");
	chk_full_at_zero: assert property (
		dec_valid && dec.len == PFD_LEN_FULL && !dec.illegal |-> dec.parcel_idx == 2'h0)
		else $error("legal full-word form outside parcel zero");
	chk_alt_opcode: assert property (
		dec_valid |-> dec.primary_opcode_alt[8:3] == dec.primary_opcode
		&& (dec.len == PFD_LEN_FULL || dec.primary_opcode_alt[2:0] == dec.sel_i))
		else $error("9-bit opcode is not opcode joined with first selector");
	chk_pass_nowrite: assert property (
		dec_valid && dec.primary_opcode inside {[6'h30:6'h32]} && dec.sel_i == 3'h0
		|-> dec.is_pass && !dec.reg_write_en)
		else $error("two-parcel pass writes a register");
	chk_grp46_pass: assert property (
		dec_valid && dec.primary_opcode == 6'h26 && !dec.primary_opcode_alt[2]
		|-> dec.is_pass && dec.len == PFD_LEN_ONE)
		else $error("group 46 filler not a one-parcel pass");
	chk_shift_count: assert property (
		dec_valid && dec.len == PFD_LEN_ONE
		|-> dec.shift_mask_count == {dec.sel_j, dec.sel_k} && dec.k_operand == 18'h0)
		else $error("shift count differs from joined selectors");
	chk_branch_clear: assert property (branch_taken |=> !dec_valid)
		else $error("decoded output survived a branch");
	chk_hold_dec: assert property (dec_valid && !dec_ready && !branch_taken |=> dec_valid && $stable(dec))
		else $error("decoded output changed before it was taken");
endmodule : pfd_decoder_sva

bind pfd_decoder pfd_decoder_sva u_sva (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .branch_taken(branch_taken),
	.dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec));

// ==== tb/pfd_fetch_model.sv ====
// instruction word supply model feeding the decoder one word at a time
`timescale 1ns/1ps

module pfd_fetch_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        word_ready,
	input  wire logic        slow,
	output logic             word_valid,
	output logic [59:0]      word_data
);
	logic [59:0] q[$];
	logic        gap_r;
	// words are handed over whole; branch targets always start a fresh word
	task push(input logic [59:0] w);
		q.push_back(w);
	endtask : push
	function int pending();
		return q.size() + int'(word_valid);
	endfunction : pending
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_valid <= 1'b0;
			word_data  <= 60'h0;
			gap_r      <= 1'b0;
		end else if (word_valid && word_ready) begin
			word_valid <= 1'b0;
			// released lines show the inverse so stale data is never mistaken for fresh
			word_data  <= ~word_data;
			gap_r      <= slow;
		end else if (!word_valid && !gap_r && q.size() > 0) begin
			word_valid <= 1'b1;
			word_data  <= q.pop_front();
		end else begin
			gap_r <= 1'b0;
		end
	end
endmodule : pfd_fetch_model

// ==== tb/pfd_decoder_tb_top.sv ====
// self-checking bench for the parcel format decoder
`timescale 1ns/1ps
`include "pfd_consts.svh"

module pfd_decoder_tb_top;
	import pfd_pkg::*;
	logic        clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, word_valid, word_ready;
	logic        branch_taken, dec_valid, dec_ready, slow, red, hold;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd, lfsr, r;
	logic [3:0]  wb_sel_i;
	logic [59:0] word_data;
	pfd_dec_s    dec;
	pfd_opnd_s   opnd;
	pfd_wr_s     rf_wr;
	int          n_fail, samples_checked, n_iss;
	pfd_dec_s    exp_q[$];
	logic [17:0] a_m[8], b_m[8];
	logic [59:0] x_m[8];
	localparam logic [63:0] LONG = `PFD_LONG_OPC_MASK;
	logic [5:0]  optab[8] = '{6'h26, 6'h30, 6'h31, 6'h01, 6'h10, 6'h20, 6'h32, 6'h28};

	pfd_decoder DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .word_valid(word_valid),
		.word_data(word_data), .word_ready(word_ready), .branch_taken(branch_taken),
		.dec_valid(dec_valid), .dec_ready(dec_ready), .dec(dec), .opnd(opnd), .rf_wr(rf_wr));
	pfd_fetch_model fetch (.clk(clk), .arst_n(arst_n), .word_ready(word_ready), .slow(slow),
		.word_valid(word_valid), .word_data(word_data));

	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
		return lfsr;
	endfunction : rnd
	function logic [59:0] rand_word();
		logic [59:0] w;
		logic [31:0] v;
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			w[59-15*i -: 15] = {optab[v[2:0]], v[11:3]};
		end
		return w;
	endfunction : rand_word
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer
	task rf_put(input pfd_rf_e f, input logic [2:0] s, input logic [59:0] d);
		@(posedge clk);
		rf_wr <= '{1'b1, f, s, d};
		@(posedge clk);
		rf_wr.en <= 1'b0;
		if (f == PFD_RF_A) a_m[s] = d[17:0];
		else if (f == PFD_RF_B && s != 3'h0) b_m[s] = d[17:0];
		else if (f == PFD_RF_X) x_m[s] = d;
	endtask : rf_put
	// reference decode of one word into the expected issue queue
	task automatic model_word(input logic [59:0] w);
		int          p;
		logic [14:0] pc, nx;
		pfd_dec_s    e;
		p = 0;
		while (p < 4) begin
			pc = w[59-15*p -: 15];
			nx = (p < 3) ? w[44-15*p -: 15] : 15'h0;
			e = '0;
			e.parcel_idx = p[1:0];
			e.primary_opcode_alt = pc[14:6];
			e.sel_j = pc[5:3];
			if (pc[14:9] == 6'h26 && pc[8] && !red) begin
				e.len = PFD_LEN_FULL;
				e.illegal = (p != 0);
				e.cm.source_field_addr = w[35:18];
				e.cm.result_field_addr = w[17:0];
				e.cm.char_count_high = {6'h0, w[50:48]};
				e.cm.char_count_low = w[47:44];
				e.cm.char_count = {6'h0, w[50:44]};
				e.cm.source_char_offset = w[43:40];
				e.cm.result_char_offset = w[39:36];
				if (w[59:51] == `PFD_OPC_IND_MOVE) begin
					e.cm.indirect = 1'b1;
					e.cm.char_count_high = w[50:42];
					e.cm.char_count_low = w[41:38];
					e.cm.char_count = {w[50:42], w[41:38]};
					e.cm.source_char_offset = 4'h0;
					e.cm.result_char_offset = 4'h0;
				end
				p = 4;
			end else if (LONG[pc[14:9]]) begin
				e.len = PFD_LEN_TWO;
				e.illegal = (p == 3) && !red;
				e.k_operand = {pc[2:0], nx};
				e.is_pass = pc[14:9] inside {[6'h30:6'h32]} && pc[8:6] == 3'h0;
				p += 2;
			end else begin
				e.len = PFD_LEN_ONE;
				e.sel_k = pc[2:0];
				e.shift_mask_count = pc[5:0];
				e.is_pass = pc[14:9] == 6'h26 && (red || !pc[8]);
				p += 1;
			end
			exp_q.push_back(e);
			n_iss++;
		end
	endtask : model_word
	task run_word(input logic [59:0] w);
		model_word(w);
		fetch.push(w);
	endtask : run_word
	task drain;
		for (int t = 0; t < 3000 && (exp_q.size() > 0 || fetch.pending() > 0); t++) @(posedge clk);
		chk("drained", exp_q.size(), 0);
	endtask : drain
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		r = rnd();
		dec_ready <= !hold && (r[0] | r[1]);
		if (dec_valid === 1'b1 && dec_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected_issue", 1, 0);
			end else if (exp_q[0].illegal) begin
				chk("dec_illegal", {dec.len, dec.parcel_idx, dec.illegal}, {exp_q[0].len, exp_q[0].parcel_idx, 1'b1});
			end else begin
				chk("dec", {dec.len, dec.parcel_idx, dec.primary_opcode_alt, dec.shift_mask_count, dec.k_operand, dec.is_pass}, {exp_q[0].len, exp_q[0].parcel_idx, exp_q[0].primary_opcode_alt, exp_q[0].shift_mask_count, exp_q[0].k_operand, exp_q[0].is_pass});
				chk("reg_write_en", dec.reg_write_en, !exp_q[0].is_pass && exp_q[0].len != PFD_LEN_FULL);
				if (exp_q[0].len == PFD_LEN_FULL) begin
					chk("cm", dec.cm[56:0], exp_q[0].cm[56:0]);
					chk("cm_desc", dec.cm[70:57], exp_q[0].cm[70:57]);
				end else begin
					chk("opnd_ab", {opnd.a_j, opnd.b_j, opnd.b_k}, {a_m[exp_q[0].sel_j], b_m[exp_q[0].sel_j], b_m[exp_q[0].sel_k]});
					chk("opnd_x", opnd.x_k, x_m[exp_q[0].sel_k]);
					chk("opnd_xj", opnd.x_j, x_m[exp_q[0].sel_j]);
				end
			end
			if (exp_q.size() > 0) void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		{clk, wb_cyc_i, wb_stb_i, wb_we_i, branch_taken, dec_ready, slow, red, hold} = '0;
		{wb_adr_i, wb_dat_i, wb_sel_i, rf_wr} = '0;
		{n_fail, samples_checked, n_iss} = '0;
		arst_n = 1'b0;
		lfsr = 32'hd4b3bac4;
		foreach (a_m[i]) {a_m[i], b_m[i], x_m[i]} = '0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		wb_xfer(1'b0, `PFD_REG_CTRL, 32'h0, rd);
		chk("ctrl_reset", rd, 0);
		wb_xfer(1'b0, 8'hFC, 32'h0, rd);
		chk("unmapped_read", rd, 0);
		for (int i = 0; i < 24; i++) rf_put(pfd_rf_e'(3'h1 << (i / 8)), i[2:0], 60'({rnd(), rnd()}));
		run_word({9'h135, 3'h5, 4'hA, 4'h3, 4'h7, 18'h25A5A, 18'h12345});
		run_word({9'h134, 9'h1AB, 4'hC, 2'h3, 18'h3FFFF, 18'h00001});
		for (int ph = 0; ph < 2; ph++) begin
			slow <= ph[0];
			run_word({6'h30, 9'h02A, 15'h7ABC, 6'h26, 9'h1FF, 6'h26, 9'h115});
			run_word({6'h10, 9'h123, 6'h20, 9'h0AA, 6'h10, 9'h055, 6'h01, 9'h1C7});
			repeat (12) run_word(rand_word());
			drain();
			wb_xfer(1'b0, `PFD_REG_STATUS, 32'h0, rd);
			chk("status_idle", rd, 0);
			wb_xfer(1'b1, `PFD_REG_CTRL, 32'hFFFF_FFFD, rd);
			wb_xfer(1'b0, `PFD_REG_CTRL, 32'h0, rd);
			chk("ctrl_rw", rd, 1);
			red = 1'b1;
		end
		wb_xfer(1'b1, `PFD_REG_CTRL, 32'h0000_0003, rd);
		run_word(rand_word());
		repeat (20) @(posedge clk);
		wb_xfer(1'b0, `PFD_REG_STATUS, 32'h0, rd);
		chk("status_halt", rd, 32'hC);
		wb_xfer(1'b1, `PFD_REG_CTRL, 32'h0000_0001, rd);
		drain();
		hold = 1'b1;
		run_word({6'h10, 9'h011, 6'h10, 9'h022, 6'h10, 9'h033, 6'h10, 9'h044});
		for (int t = 0; t < 100 && dec_valid !== 1'b1; t++) @(posedge clk);
		@(posedge clk);
		branch_taken <= 1'b1;
		@(posedge clk);
		branch_taken <= 1'b0;
		#1;
		chk("branch_drop", dec_valid, 0);
		n_iss = n_iss - exp_q.size() + 1;
		exp_q.delete();
		run_word({6'h20, 9'h1A5, 6'h01, 9'h003, 15'h1234, 6'h10, 9'h077});
		hold = 1'b0;
		drain();
		wb_xfer(1'b0, `PFD_REG_ISSUED, 32'h0, rd);
		chk("issued", rd, n_iss);
		wb_xfer(1'b1, `PFD_REG_ISSUED, 32'h0, rd);
		wb_xfer(1'b0, `PFD_REG_ISSUED, 32'h0, rd);
		chk("issued_clear", rd, 0);
		finish_test;
	end
endmodule : pfd_decoder_tb_top
